// >>> rtl/olsc_frame_latch.sv
// frame-boundary sampler for one enable bit
`timescale 1ns/1ps
module olsc_frame_latch (
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_sof,
    input  wire logic i_live,
    output logic      o_frame
);
    logic frame_reg;
    logic frame_next;

    // an enable written mid-frame only counts from the next start of frame
    always_comb begin
        frame_next = i_sof ? i_live : frame_reg;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            frame_reg <= 1'b0;
        end else begin
            frame_reg <= frame_next;
        end
    end

    assign o_frame = frame_reg;
endmodule : olsc_frame_latch

// >>> rtl/olsc_list_ctrl.sv
// list enables, control/bulk ratio and scheduling overrun count
//
// Behaviour
// - A set control enable runs the control list from the next frame, a clear one stops it at the next service attempt.
// - The control enable is sampled at each control service attempt and the list is skipped while it is zero.
// - On an isochronous descriptor the periodic walk goes on if iso enable is set, else it jumps to non-periodic lists.
// - A change of the iso enable takes effect from the next frame only.
// - The periodic enable is checked before the periodic list starts and changes act from the next frame.
// - The ratio field 00b..11b selects one to four control descriptors per bulk descriptor.
// - Before each non-periodic service the served-count is compared with the ratio to choose control or bulk.
// - The served-count survives frame boundaries.
// - Command/status writes set the bits 3:0 written as one and leave others, reads return everything.
// - An unfinished periodic list at end of frame is a scheduling overrun, counted in bits 17:16 of command/status.
// - An overrun increments the count and raises the overrun flag of the interrupt status.
// - The count starts at 00b, wraps past 11b, and counts even when the flag is already set.
`timescale 1ns/1ps
module olsc_list_ctrl
    import olsc_pkg::*;
#(
    parameter int RATIO_W = 2
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [31:0] i_reg_wdata,
    input  wire logic        i_sof,
    input  wire logic        i_eof,
    input  wire logic        i_periodic_busy,
    input  wire logic        i_iso_found,
    input  wire logic        i_nonper_req,
    input  wire logic        i_control_nonempty,
    input  wire logic        i_bulk_ready,
    output logic [31:0]      o_reg_rdata,
    output logic             o_periodic_go,
    output logic             o_iso_abort,
    output logic             o_serve_control,
    output logic             o_serve_bulk,
    output logic             o_overrun_pulse
);
    import olsc_pkg::*;

    if (RATIO_W != 2) begin : g_ratio_check
        $error("olsc_list_ctrl: ratio field must be 2 bits");
    end

    logic [4:0]  ctrl_reg;
    logic [4:0]  ctrl_next;
    logic [3:0]  cmd_reg;
    logic [3:0]  cmd_next;
    logic [1:0]  ovr_reg;
    logic [1:0]  ovr_next;
    logic [2:0]  svc_reg;
    logic [2:0]  svc_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        per_go_reg;
    logic        per_go_next;
    logic        iso_abort_reg;
    logic        iso_abort_next;
    logic        sc_reg;
    logic        sc_next;
    logic        sb_reg;
    logic        sb_next;
    logic        ovr_p_reg;
    logic        ovr_p_next;
    logic        ctrl_frame;
    logic        per_frame;
    logic        iso_frame;
    logic        overrun;
    logic        ratio_met;
    logic [2:0]  ratio_cnt;

    // frame-aligned copies of the three enables
    olsc_frame_latch u_ctrl_en (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_sof     (i_sof),
        .i_live    (ctrl_reg[BIT_CONTROL_EN]),
        .o_frame   (ctrl_frame)
    );
    olsc_frame_latch u_per_en (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_sof     (i_sof),
        .i_live    (ctrl_reg[BIT_PERIODIC_EN]),
        .o_frame   (per_frame)
    );
    olsc_frame_latch u_iso_en (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_sof     (i_sof),
        .i_live    (ctrl_reg[BIT_ISO_EN]),
        .o_frame   (iso_frame)
    );

    assign overrun   = i_eof & i_periodic_busy;
    assign ratio_cnt = {1'b0, ctrl_reg[BIT_RATIO_HI:BIT_RATIO_LO]} + SVC_STEP;
    assign ratio_met = (svc_reg >= ratio_cnt);

    always_comb begin
        ctrl_next   = ctrl_reg;
        cmd_next    = cmd_reg;
        ovr_next    = ovr_reg;
        rdata_next  = READ_ZERO;
        if (i_reg_wr && i_reg_addr == OFS_LIST_CONTROL) begin
            ctrl_next = i_reg_wdata[4:0] & CTRL_WMASK;
        end
        if (i_reg_wr && i_reg_addr == OFS_COMMAND_STATUS) begin
            cmd_next = cmd_reg | (i_reg_wdata[3:0] & CMD_WMASK);
        end
        if (overrun) begin
            ovr_next = ovr_reg + OVR_STEP;
        end
        if (i_reg_rd) begin
            if (i_reg_addr == OFS_LIST_CONTROL) begin
                rdata_next[4:0] = ctrl_reg;
            end else if (i_reg_addr == OFS_COMMAND_STATUS) begin
                rdata_next[3:0] = cmd_reg;
                rdata_next[BIT_OVR_HI:BIT_OVR_LO] = ovr_reg;
            end
        end
    end

    // non-periodic arbitration, count kept across frames
    always_comb begin
        svc_next       = svc_reg;
        sc_next        = 1'b0;
        sb_next        = 1'b0;
        // the frame copy only updates at this edge, so the live bit decides the frame now starting
        per_go_next    = i_sof & ctrl_reg[BIT_PERIODIC_EN];
        iso_abort_next = i_iso_found & ~iso_frame;
        ovr_p_next     = overrun;
        if (i_nonper_req) begin
            if (ctrl_frame && ctrl_reg[BIT_CONTROL_EN] && i_control_nonempty && !ratio_met) begin
                sc_next  = 1'b1;
                svc_next = svc_reg + SVC_STEP;
            end else if (i_bulk_ready) begin
                sb_next  = 1'b1;
                svc_next = SVC_RESET;
            end else if (ratio_met) begin
                svc_next = SVC_RESET;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ctrl_reg      <= 5'h00;
            cmd_reg       <= 4'h0;
            ovr_reg       <= OVR_RESET;
            svc_reg       <= SVC_RESET;
            rdata_reg     <= READ_ZERO;
            per_go_reg    <= 1'b0;
            iso_abort_reg <= 1'b0;
            sc_reg        <= 1'b0;
            sb_reg        <= 1'b0;
            ovr_p_reg     <= 1'b0;
        end else begin
            ctrl_reg      <= ctrl_next;
            cmd_reg       <= cmd_next;
            ovr_reg       <= ovr_next;
            svc_reg       <= svc_next;
            rdata_reg     <= rdata_next;
            per_go_reg    <= per_go_next;
            iso_abort_reg <= iso_abort_next;
            sc_reg        <= sc_next;
            sb_reg        <= sb_next;
            ovr_p_reg     <= ovr_p_next;
        end
    end

    assign o_reg_rdata     = rdata_reg;
    assign o_periodic_go   = per_go_reg;
    assign o_iso_abort     = iso_abort_reg;
    assign o_serve_control = sc_reg;
    assign o_serve_bulk    = sb_reg;
    assign o_overrun_pulse = ovr_p_reg;

    a_ovr_count_step: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        overrun |=> ovr_reg == $past(ovr_reg) + OVR_STEP) else $error("overrun count did not step");
    a_ovr_flag_pulse: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        overrun |=> o_overrun_pulse) else $error("overrun flag not raised");
    a_cmd_write_set: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_reg_wr && i_reg_addr == OFS_COMMAND_STATUS |=> ((cmd_reg & $past(cmd_reg)) == $past(cmd_reg)) &&
        ((cmd_reg & $past(i_reg_wdata[3:0])) == $past(i_reg_wdata[3:0])))
        else $error("command bit lost on write");
    a_ctrl_gated: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_serve_control |-> $past(ctrl_frame) && $past(ctrl_reg[BIT_CONTROL_EN]))
        else $error("control served while off");
    a_ctrl_sample: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_nonper_req && !ctrl_reg[BIT_CONTROL_EN] |=> !o_serve_control) else $error("control not skipped");
    a_per_frame: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_periodic_go |-> $past(i_sof) && per_frame) else $error("periodic start outside frame");
    a_iso_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_sof |=> iso_frame == $past(iso_frame)) else $error("iso enable changed mid frame");
    a_iso_abort: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_iso_found && !iso_frame |=> o_iso_abort) else $error("iso abort missing");
    a_ratio_limit: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_serve_control |-> svc_reg <= ratio_cnt) else $error("ratio exceeded");
    a_bulk_restart: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_serve_bulk |-> svc_reg == SVC_RESET) else $error("count not restarted");
    a_count_frame: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_sof && !i_nonper_req |=> svc_reg == $past(svc_reg)) else $error("count cleared at frame");
endmodule : olsc_list_ctrl

// >>> rtl/olsc_pkg.sv
// constants for the list service control block
package olsc_pkg;
    localparam logic [7:0]  OFS_LIST_CONTROL   = 8'h04;
    localparam logic [7:0]  OFS_COMMAND_STATUS = 8'h08;
    localparam int          BIT_RATIO_LO       = 0;
    localparam int          BIT_RATIO_HI       = 1;
    localparam int          BIT_PERIODIC_EN    = 2;
    localparam int          BIT_ISO_EN         = 3;
    localparam int          BIT_CONTROL_EN     = 4;
    localparam int          BIT_OVR_LO         = 16;
    localparam int          BIT_OVR_HI         = 17;
    localparam logic [4:0]  CTRL_WMASK         = 5'h1f;
    localparam logic [3:0]  CMD_WMASK          = 4'hf;
    localparam logic [1:0]  OVR_RESET          = 2'h0;
    localparam logic [1:0]  OVR_STEP           = 2'h1;
    localparam logic [2:0]  SVC_RESET          = 3'h0;
    localparam logic [2:0]  SVC_STEP           = 3'h1;
    localparam logic [31:0] READ_ZERO          = 32'h0;
endpackage : olsc_pkg

// >>> test/olsc_host_model.sv
// host software model: register access over the offset bus
`timescale 1ns/1ps
module olsc_host_model (
    input  wire logic        i_clk_sys,
    input  wire logic [31:0] i_rdata,
    output logic [7:0]       o_addr,
    output logic             o_wr,
    output logic             o_rd,
    output logic [31:0]      o_wdata
);
    initial {o_addr, o_wr, o_rd, o_wdata} = '0;
    // ratio restore after reset and list edits with control off are the caller's duty
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        #1 {o_addr, o_wdata, o_wr} = {a, d, 1'b1};
        @(posedge i_clk_sys);
        #1 o_wr = 1'b0;
        o_wdata = ~d; // released data shows no stale value
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        #1 {o_addr, o_rd} = {a, 1'b1};
        @(posedge i_clk_sys);
        #1 o_rd = 1'b0;
        d = i_rdata;
    endtask : rd
endmodule : olsc_host_model

// >>> test/olsc_list_ctrl_test.sv
// self-checking bench for the list service control block
`timescale 1ns/1ps
module olsc_list_ctrl_test;
    import olsc_pkg::*;
    logic        i_clk_sys = 1'b0;
    logic        i_rst     = 1'b1;
    logic [7:0]  addr;
    logic        wr, rd;
    logic [31:0] wdata, rdata, v;
    logic [3:0]  ev   = 4'h0; // req, iso, eof, sof
    logic        busy = 1'b0;
    logic        full = 1'b0;
    logic        bulk = 1'b0;
    logic [4:0]  outs;
    logic [7:0]  cnt [5] = '{default: 8'h0};
    int          fail_count = 0;
    int          tests_run  = 0;
    always #4 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        for (int k = 0; k < 5; k++) cnt[k] <= cnt[k] + 8'(outs[k]);
    end
    olsc_list_ctrl i_dut (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_wdata(wdata), .i_sof(ev[0]), .i_eof(ev[1]), .i_periodic_busy(busy), .i_iso_found(ev[2]),
        .i_nonper_req(ev[3]), .i_control_nonempty(full), .i_bulk_ready(bulk), .o_reg_rdata(rdata),
        .o_periodic_go(outs[0]), .o_iso_abort(outs[1]), .o_serve_control(outs[2]),
        .o_serve_bulk(outs[3]), .o_overrun_pulse(outs[4]));
    olsc_host_model i_host (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
        .o_rd(rd), .o_wdata(wdata));
    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg
    task chk_cnt(input int k, input logic [7:0] e);
        chk_reg({24'h0, cnt[k]}, {24'h0, e});
    endtask : chk_cnt
    task clr;
        foreach (cnt[k]) cnt[k] = 8'h0;
    endtask : clr
    // one-cycle event, then room for the registered answer
    task fire(input logic [3:0] e);
        @(posedge i_clk_sys);
        #1 ev = e;
        @(posedge i_clk_sys);
        #1 ev = 4'h0;
        repeat (2) @(posedge i_clk_sys);
        #1;
    endtask : fire
    task t_regs;
        i_host.rd(OFS_COMMAND_STATUS, v); chk_reg(v, READ_ZERO);
        i_host.wr(OFS_LIST_CONTROL, 32'hffff_ffff);
        i_host.rd(OFS_LIST_CONTROL, v); chk_reg(v, 32'h1f);
        i_host.wr(OFS_COMMAND_STATUS, 32'h0003_0001);
        i_host.wr(OFS_COMMAND_STATUS, 32'h4);
        i_host.wr(OFS_COMMAND_STATUS, 32'h0);
        i_host.rd(OFS_COMMAND_STATUS, v); chk_reg(v, 32'h5);
        i_host.rd(8'h0c, v); chk_reg(v, 32'h0);
    endtask : t_regs
    task t_ctrl;
        full = 1'b1;
        i_host.wr(OFS_LIST_CONTROL, 32'h0); // ratio restored after reset
        fire(4'h1);
        i_host.wr(OFS_LIST_CONTROL, 32'h13); clr; fire(4'h8); chk_cnt(2, 0);
        fire(4'h1); clr; fire(4'h8); chk_cnt(2, 1);
        i_host.wr(OFS_LIST_CONTROL, 32'h03); clr; fire(4'h8); chk_cnt(2, 0);
    endtask : t_ctrl
    task t_ratio;
        bulk = 1'b1;
        for (int r = 0; r < 4; r++) begin
            i_host.wr(OFS_LIST_CONTROL, 32'h10 | 32'(r));
            fire(4'h1);
            clr;
            for (int k = 0; k < 6 && cnt[3] == 8'h0; k++) fire(4'h8);
            clr; fire(4'h8); fire(4'h1); // frame boundary keeps the served count
            repeat (r) fire(4'h8);
            chk_cnt(2, 8'(r + 1)); chk_cnt(3, 0);
            fire(4'h8); chk_cnt(3, 1); chk_cnt(2, 8'(r + 1));
        end
    endtask : t_ratio
    task t_periodic;
        i_host.wr(OFS_LIST_CONTROL, 32'h04); clr; fire(4'h1); chk_cnt(0, 1);
        fire(4'h4); chk_cnt(1, 1);
        i_host.wr(OFS_LIST_CONTROL, 32'h0c); clr; fire(4'h4); chk_cnt(1, 1);
        fire(4'h1); clr; fire(4'h4); chk_cnt(1, 0);
        i_host.wr(OFS_LIST_CONTROL, 32'h0); clr; fire(4'h1); chk_cnt(0, 0);
    endtask : t_periodic
    task t_overrun;
        clr; fire(4'h2); chk_cnt(4, 0);
        busy = 1'b1;
        for (int k = 1; k < 6; k++) begin
            fire(4'h2);
            i_host.rd(OFS_COMMAND_STATUS, v);
            chk_reg({30'h0, v[BIT_OVR_HI:BIT_OVR_LO]}, 32'(k % 4));
        end
        chk_cnt(4, 5);
    endtask : t_overrun
    task print_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (12) @(posedge i_clk_sys);
        #1 i_rst = 1'b0;
        t_regs;
        t_ctrl;
        t_ratio;
        t_periodic;
        t_overrun;
        print_verdict;
    end
    initial begin
        #200000;
        fail_count++;
        print_verdict;
    end
endmodule : olsc_list_ctrl_test
